/* alert_first_detect.sv */
/*
  Detects that this device asserted the shared alert line while it was still
  high. Assumes alert_line_in is the sampled wire level (low = asserted).
*/
`timescale 1ns/1ps
module alert_first_detect (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic alert_request,
  input  wire logic alert_line_in,
  output logic      first_event
);
  typedef struct packed {
    logic req_d;
    logic line_d;
  } state_t;
  state_t cur;
  state_t next_cur;

  always_comb begin
    next_cur.req_d  = alert_request;
    next_cur.line_d = alert_line_in;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cur <= 2'h1;
    end else begin
      cur <= next_cur;
    end
  end

  // Rising own request while the wire was still high the cycle before
  assign first_event = alert_request && !cur.req_d && cur.line_d; // RL3

  a_first_needs_high : assert property (@(posedge clk) disable iff (rst)
    first_event |-> $past(alert_line_in)) else $error("first event with line low"); // RL3
endmodule // alert_first_detect

/* host_model.sv */
/*
  Host stand-in for the status bank: byte reads and writes by strobe, plus the
  shared alert wire with its pull-up. Assumes the bench calls its tasks.
*/
`timescale 1ns/1ps
module host_model (
  input  wire logic       clk,
  input  wire logic [7:0] read_data,
  input  wire logic       read_valid,
  input  wire logic       alert_request,
  input  wire logic       other_pull,
  output logic [7:0]      cmd_code,
  output logic            write_strobe,
  output logic [7:0]      write_data,
  output logic            read_strobe,
  output logic            alert_line_in
);
  // ==========================================================
  // Wire and bus tasks
  // Open-drain wire: pulled up, low while either party pulls it
  assign alert_line_in = ~(alert_request | other_pull);
  initial begin
    cmd_code     = 8'h00;
    write_strobe = 1'b0;
    write_data   = 8'h00;
    read_strobe  = 1'b0;
  end
  task automatic write_byte(input logic [7:0] c, input logic [7:0] d);
    @(posedge clk);
    cmd_code     <= c;
    write_data   <= d;
    write_strobe <= 1'b1;
    @(posedge clk);
    write_strobe <= 1'b0;
    // Released lines show junk so that a stale value is never trusted
    cmd_code     <= ~c;
    write_data   <= ~d;
  endtask
  task automatic read_byte(input logic [7:0] c, output logic [7:0] d, output logic v);
    @(posedge clk);
    cmd_code    <= c;
    read_strobe <= 1'b1;
    @(posedge clk);
    read_strobe <= 1'b0;
    cmd_code    <= ~c;
    #1;
    v = read_valid;
    d = read_data;
  endtask
endmodule // host_model

/* status_flags_bank.sv */
/*
  Auxiliary PMBus status bank: first-to-alert register and vendor fault
  register, with clears and summary bits. Assumes an upstream protocol engine
  presents decoded byte reads and writes as single-cycle strobes on clk.
*/
`timescale 1ns/1ps

// Contract
// RL1: Reading command 7Fh returns one byte with the first-alert flag in bit 0; writes are accepted.
// RL2: The first-alert flag never drives the alert line itself.
// RL3: The first-alert flag sets when this device asserts alert while the line was still high.
// RL4: Bits 7..1 of 7Fh and bits 3..2 of 80h read zero and are read-only.
// RL5: Clear-faults, output turn-on, or writing 1 to a flag's bit clears latched flags.
// RL6: The summary bit is the OR of the supported first-alert flags.
// RL7: Reading command 80h returns one byte of vendor flags; writes are accepted.
// RL8: The alert mask never suppresses vendor flags.
// RL9: A fault-disable bit blocks both the fault response and its vendor flag.
// RL10: Bit 7 of 80h is a live discontinuous-mode indication that raises no alert or summary.
// RL11: Bit 6 latches on controller thermal shutdown.
// RL12: Bit 5 latches on driver undervoltage, power-stage thermal shutdown or input lockout.
// RL13: Bit 4 latches on a power-stage communication error.
// RL14: Bit 1 latches on power-stage thermal shutdown.
// RL15: Bit 0 reports power-stage undervoltage and is write-one-to-clear.
// RL16: Writing 0 leaves flags alone; writes to read-only bits are ignored.
module status_flags_bank (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] cmd_code,
  input  wire logic       write_strobe,
  input  wire logic [7:0] write_data,
  input  wire logic       read_strobe,
  output logic [7:0]      read_data,
  output logic            read_valid,
  input  wire logic       clear_faults,
  input  wire logic       output_turn_on,
  input  wire logic       alert_request,
  input  wire logic       alert_line_in,
  input  wire logic       alert_mask_setting,
  input  wire logic [5:0] fault_disable,
  input  wire logic       discontinuous_mode_live,
  input  wire logic       controller_thermal_shutdown,
  input  wire logic       driver_supply_undervoltage,
  input  wire logic       power_stage_thermal,
  input  wire logic       power_input_lockout,
  input  wire logic       power_stage_link_error,
  input  wire logic       power_stage_undervoltage,
  output logic            fault_response_enable,
  output logic            first_alert_summary,
  output logic            vendor_summary
);
  // ==========================================================================
  // Register state
  typedef struct packed {
    logic [7:0] read_data;
    logic       read_valid;
  } state_t;
  state_t cur;
  state_t next_cur;

  logic       first_event;
  logic       first_alert_flag;
  logic       bulk_clear;
  logic [7:0] vendor_flags;
  logic [7:0] vendor_set;
  logic [7:0] vendor_clr;
  logic       first_clr;
  // Write-one-to-clear image of the current write, shared by both registers
  logic [7:0] write_clr;
  logic [7:0] first_alert_status;
  logic [7:0] vendor_fault_status;

  // Index of fault_disable for each vendor latched bit
  function automatic logic disabled_for(input int pos, input logic [5:0] dis);
    case (pos)
      status_flags_pkg::BIT_CTRL_OT:  disabled_for = dis[0];
      status_flags_pkg::BIT_PS_FAULT: disabled_for = dis[1];
      status_flags_pkg::BIT_PS_LINK:  disabled_for = dis[2];
      status_flags_pkg::BIT_POWER_STAGE_THERMAL_FLAG:    disabled_for = dis[3];
      status_flags_pkg::BIT_POWER_STAGE_UNDERVOLTAGE_FLAG:    disabled_for = dis[4];
      default:                        disabled_for = 1'b0;
    endcase
  endfunction

  // Only one side effect of writes: W1C on latched positions
  function automatic logic [7:0] w1c_mask(input logic [7:0] code, input logic [7:0] data,
                                          input logic wr);
    if (wr && code == status_flags_pkg::CMD_FIRST_ALERT) begin
      w1c_mask = data & status_flags_pkg::FIRST_ALERT_W1C; // RL16
    end else if (wr && code == status_flags_pkg::CMD_VENDOR_FAULT) begin
      w1c_mask = data & status_flags_pkg::VENDOR_FAULT_W1C; // RL16
    end else begin
      w1c_mask = 8'h00;
    end
  endfunction

  // ==========================================================================
  // Event capture
  assign bulk_clear = clear_faults | output_turn_on; // RL5

  alert_first_detect u_first (
    .clk           (clk),
    .rst           (rst),
    .alert_request (alert_request),
    .alert_line_in (alert_line_in),
    .first_event   (first_event)
  );

  // Fault responses run only while every disable bit is clear; the mask is not consulted
  assign fault_response_enable = ~|fault_disable; // RL9 RL8

  always_comb begin
    vendor_set = 8'h00;
    vendor_set[status_flags_pkg::BIT_CTRL_OT]  = controller_thermal_shutdown; // RL11
    vendor_set[status_flags_pkg::BIT_PS_FAULT] = driver_supply_undervoltage
      | power_stage_thermal | power_input_lockout; // RL12
    vendor_set[status_flags_pkg::BIT_PS_LINK]  = power_stage_link_error; // RL13
    vendor_set[status_flags_pkg::BIT_POWER_STAGE_THERMAL_FLAG]    = power_stage_thermal; // RL14
    vendor_set[status_flags_pkg::BIT_POWER_STAGE_UNDERVOLTAGE_FLAG]    = power_stage_undervoltage; // RL15
    for (int i = 0; i < 8; i++) begin
      if (disabled_for(i, fault_disable)) begin
        vendor_set[i] = 1'b0; // RL9
      end
    end
  end

  assign write_clr  = w1c_mask(cmd_code, write_data, write_strobe); // RL16
  assign vendor_clr = write_clr | {8{bulk_clear}}; // RL5
  assign first_clr  = write_clr[status_flags_pkg::FIRST_ALERT_BIT] | bulk_clear; // RL5

  w1c_flag u_first_flag (
    .clk       (clk),
    .rst       (rst),
    .set_event (first_event),
    .clear     (first_clr),
    .flag      (first_alert_flag)
  );

  // ==========================================================================
  // Latched vendor bits
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_vendor
      if (status_flags_pkg::VENDOR_FAULT_W1C[g]) begin : g_latch
        w1c_flag u_flag (
          .clk       (clk),
          .rst       (rst),
          .set_event (vendor_set[g]),
          .clear     (vendor_clr[g]),
          .flag      (vendor_flags[g])
        );
      end else begin : g_none
        assign vendor_flags[g] = 1'b0; // RL4
      end
    end
  endgenerate

  // ==========================================================================
  // Read image and summaries
  assign first_alert_status = {7'h00, first_alert_flag}; // RL4 RL1
  assign vendor_fault_status = {discontinuous_mode_live, vendor_flags[6:0]}; // RL10 RL7

  // Summary excludes the live bit; the first-alert flag feeds no alert path
  assign first_alert_summary = |(first_alert_status & status_flags_pkg::FIRST_ALERT_W1C); // RL6 RL2
  assign vendor_summary = |(vendor_flags & status_flags_pkg::VENDOR_FAULT_W1C); // RL10

  always_comb begin
    next_cur = cur;
    next_cur.read_valid = 1'b0;
    if (read_strobe) begin
      next_cur.read_valid = 1'b1;
      case (cmd_code)
        status_flags_pkg::CMD_FIRST_ALERT:  next_cur.read_data = first_alert_status; // RL1
        status_flags_pkg::CMD_VENDOR_FAULT: next_cur.read_data = vendor_fault_status; // RL7
        default:                            next_cur.read_data = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign read_data  = cur.read_data;
  assign read_valid = cur.read_valid;

  // ==========================================================================
  // Checks
  a_read_one_cycle : assert property (@(posedge clk) disable iff (rst)
    read_strobe |=> read_valid ##1 !read_valid || $past(read_strobe)) else $error("bad read valid"); // RL1
  a_first_reserved : assert property (@(posedge clk) disable iff (rst)
    (read_strobe && cmd_code == 8'h7f) |=> read_data[7:1] == 7'h00) else $error("reserved set"); // RL4
  a_vendor_reserved : assert property (@(posedge clk) disable iff (rst)
    (read_strobe && cmd_code == 8'h80) |=> read_data[3:2] == 2'h0) else $error("reserved set"); // RL4
  a_bulk_clears : assert property (@(posedge clk) disable iff (rst)
    (bulk_clear && vendor_set == 8'h00 && !first_event) |=>
      first_alert_flag == 1'b0 && vendor_flags == 8'h00) else $error("bulk clear failed"); // RL5
  a_summary_follows : assert property (@(posedge clk) disable iff (rst)
    first_alert_summary == first_alert_flag) else $error("summary mismatch"); // RL6
  a_mask_ignored : assert property (@(posedge clk) disable iff (rst)
    (controller_thermal_shutdown && !fault_disable[0]) |=> vendor_flags[6]) else $error("lost"); // RL8
  a_disable_blocks : assert property (@(posedge clk) disable iff (rst)
    (fault_disable[2] && !vendor_flags[4] && !$past(vendor_flags[4])) |=> !vendor_flags[4])
    else $error("disabled flag set"); // RL9
  a_live_dcm : assert property (@(posedge clk) disable iff (rst)
    (read_strobe && cmd_code == 8'h80) |=> read_data[7] == $past(discontinuous_mode_live))
    else $error("live bit stale"); // RL10
  a_ps_fault_cause : assert property (@(posedge clk) disable iff (rst)
    (driver_supply_undervoltage && !fault_disable[1]) |=> vendor_flags[5]) else $error("no fault"); // RL12
  a_zero_write_keeps : assert property (@(posedge clk) disable iff (rst)
    (write_strobe && write_data == 8'h00 && !bulk_clear) |=> vendor_flags >= $past(vendor_flags))
    else $error("zero write cleared"); // RL16

  c_first_alert : cover property (@(posedge clk) first_event);
  c_w1c_vendor : cover property (@(posedge clk) write_strobe && cmd_code == 8'h80 && |vendor_flags);
  c_bulk_clear : cover property (@(posedge clk) bulk_clear && first_alert_flag);
  c_live_read : cover property (@(posedge clk) read_strobe && discontinuous_mode_live);

  // ==========================================================================
  // Per-source, clear, gate and summary checks: each event must reach its own bit unless disabled
  a_link_err_sets : assert property (@(posedge clk) disable iff (rst) // RL13
    (power_stage_link_error && !fault_disable[2])
    |=> vendor_flags[4])
    else $error("link error flag did not set");
  a_power_stage_thermal_flag_sets : assert property (@(posedge clk) disable iff (rst) // RL14
    (power_stage_thermal && !fault_disable[3])
    |=> vendor_flags[1])
    else $error("stage thermal flag did not set");
  a_power_stage_undervoltage_flag_sets : assert property (@(posedge clk) disable iff (rst) // RL15
    (power_stage_undervoltage && !fault_disable[4])
    |=> vendor_flags[0])
    else $error("stage undervoltage flag did not set");
  a_thermal_cause : assert property (@(posedge clk) disable iff (rst) // RL12
    (power_stage_thermal && !fault_disable[1])
    |=> vendor_flags[5])
    else $error("stage fault missed thermal cause");
  a_lockout_cause : assert property (@(posedge clk) disable iff (rst) // RL12
    (power_input_lockout && !fault_disable[1])
    |=> vendor_flags[5])
    else $error("stage fault missed lockout cause");
  a_first_sets : assert property (@(posedge clk) disable iff (rst) // RL3
    first_event
    |=> first_alert_flag)
    else $error("first alert flag did not set");
  a_first_w1c : assert property (@(posedge clk) disable iff (rst) // RL5
    (write_strobe && cmd_code == 8'h7f && write_data[0] && !first_event)
    |=> !first_alert_flag)
    else $error("first alert flag not cleared by write");
  a_vendor_w1c : assert property (@(posedge clk) disable iff (rst) // RL5
    (write_strobe && cmd_code == 8'h80 && write_data[6] && !vendor_set[6])
    |=> !vendor_flags[6])
    else $error("vendor flag not cleared by write");
  a_turn_on_clears : assert property (@(posedge clk) disable iff (rst) // RL5
    (output_turn_on && !first_event)
    |=> !first_alert_flag)
    else $error("turn-on did not clear first alert flag");
  a_first_zero_keeps : assert property (@(posedge clk) disable iff (rst) // RL16
    (write_strobe && cmd_code == 8'h7f && !write_data[0] && !bulk_clear)
    |=> (!$past(first_alert_flag) || first_alert_flag))
    else $error("zero write cleared first alert flag");
  a_reserved_zero : assert property (@(posedge clk) disable iff (rst) // RL4
    vendor_flags[3:2] == 2'h0)
    else $error("reserved vendor bit set");
  a_response_gate : assert property (@(posedge clk) disable iff (rst) // RL9
    fault_response_enable == (fault_disable == 6'h00))
    else $error("fault response gate wrong");
  a_vendor_summary_or : assert property (@(posedge clk) disable iff (rst) // RL10
    vendor_summary == |vendor_flags[6:0])
    else $error("vendor summary includes live bit");

  // ==========================================================================
  // Read path: value, timing and hold
  a_unmapped_zero : assert property (@(posedge clk) disable iff (rst) // RL1
    (read_strobe && cmd_code != 8'h7f && cmd_code != 8'h80)
    |=> read_data == 8'h00)
    else $error("unmapped code read nonzero");
  a_first_read_value : assert property (@(posedge clk) disable iff (rst) // RL1
    (read_strobe && cmd_code == 8'h7f)
    |=> read_data[0] == $past(first_alert_flag))
    else $error("first alert read wrong");
  a_vendor_read_value : assert property (@(posedge clk) disable iff (rst) // RL7
    (read_strobe && cmd_code == 8'h80)
    |=> read_data[6:0] == $past(vendor_flags[6:0]))
    else $error("vendor read wrong");
  a_no_stray_valid : assert property (@(posedge clk) disable iff (rst) // RL1
    !read_strobe
    |=> !read_valid)
    else $error("read valid without strobe");
  a_read_data_holds : assert property (@(posedge clk) disable iff (rst) // RL1
    !read_strobe
    |=> $stable(read_data))
    else $error("read data changed without read");
endmodule // status_flags_bank

/* status_flags_pkg.sv */
/*
  Constants for the auxiliary status flag bank: command codes, bit positions,
  reset values. Assumes a PMBus protocol engine that decodes commands upstream.
*/
package status_flags_pkg;
  // ==========================================================================
  // Command codes
  localparam logic [7:0] CMD_FIRST_ALERT  = 8'h7f;
  localparam logic [7:0] CMD_VENDOR_FAULT = 8'h80;
  // ==========================================================================
  // Field positions
  localparam int FIRST_ALERT_BIT = 0;
  localparam int BIT_DCM_LIVE    = 7;
  localparam int BIT_CTRL_OT     = 6;
  localparam int BIT_PS_FAULT    = 5;
  localparam int BIT_PS_LINK     = 4;
  localparam int BIT_POWER_STAGE_THERMAL_FLAG       = 1;
  localparam int BIT_POWER_STAGE_UNDERVOLTAGE_FLAG       = 0;
  // Latched (write-one-to-clear) positions of each register
  localparam logic [7:0] FIRST_ALERT_W1C  = 8'h01;
  localparam logic [7:0] VENDOR_FAULT_W1C = 8'h73;
  localparam logic [7:0] FLAGS_RESET      = 8'h00;
endpackage

/* test_pmbus_aux_status_flags.sv */
/*
  Self-checking bench for the status bank: events, clears, disables, live bit.
  Assumes host_model drives the command strobes and the alert wire.
*/
`timescale 1ns/1ps
module test_pmbus_aux_status_flags;
  logic       clk, rst, clear_faults, output_turn_on, alert_request, other_pull;
  logic       alert_mask_setting, discontinuous_mode_live, write_strobe, read_strobe;
  logic       read_valid, alert_line_in, fault_response_enable;
  logic       first_alert_summary, vendor_summary;
  logic [5:0] fault_disable, ev;
  logic [7:0] cmd_code, write_data, read_data;
  int         miscompares, checks, cycles;
  // Bits each event should latch, in the order of ev
  localparam logic [7:0] event_bits [6] = '{8'h40, 8'h20, 8'h22, 8'h20, 8'h10, 8'h01};
  status_flags_bank dut_u (.clk, .rst, .cmd_code, .write_strobe, .write_data,
    .read_strobe, .read_data, .read_valid, .clear_faults, .output_turn_on,
    .alert_request, .alert_line_in, .alert_mask_setting, .fault_disable,
    .discontinuous_mode_live, .controller_thermal_shutdown(ev[0]),
    .driver_supply_undervoltage(ev[1]), .power_stage_thermal(ev[2]),
    .power_input_lockout(ev[3]), .power_stage_link_error(ev[4]),
    .power_stage_undervoltage(ev[5]), .fault_response_enable,
    .first_alert_summary, .vendor_summary);
  host_model host_u (.clk, .read_data, .read_valid, .alert_request, .other_pull,
    .cmd_code, .write_strobe, .write_data, .read_strobe, .alert_line_in);
  // ==========================================================
  // Clock, timeout and helpers
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      report_and_stop();
    end
  end
  task automatic check_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic check_bit(input string n, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic rd(input logic [7:0] c, input logic [7:0] e);
    logic [7:0] d;
    logic       v;
    host_u.read_byte(c, d, v);
    check_bit("read_valid", 1'b1, v);
    check_byte("read_data", e, d);
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev <= 6'h00;
  endtask
  task automatic raise_alert();
    @(posedge clk);
    alert_request <= 1'b1;
    @(posedge clk);
    alert_request <= 1'b0;
  endtask
  task automatic end_test(input string n);
    $display("test %s done, miscompares %0d", n, miscompares);
  endtask
  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ==========================================================
  // Tests
  initial begin
    {clk, clear_faults, output_turn_on, alert_request, other_pull} = 5'h00;
    {alert_mask_setting, discontinuous_mode_live, fault_disable, ev} = 14'h0000;
    {miscompares, checks, cycles} = '0;
    rst = 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    alert_mask_setting <= 1'b1;
    rd(8'h7f, 8'h00);
    rd(8'h80, 8'h00);
    rd(8'h81, 8'h00);
    check_bit("fault_response_enable", 1'b1, fault_response_enable);
    end_test("reset");
    for (int i = 0; i < 6; i++) begin
      pulse(i);
      rd(8'h80, event_bits[i]);
      check_bit("vendor_summary", 1'b1, vendor_summary);
      host_u.write_byte(8'h80, 8'h00);
      host_u.write_byte(8'h80, 8'h0c);
      rd(8'h80, event_bits[i]);
      host_u.write_byte(8'h80, event_bits[i]);
      rd(8'h80, 8'h00);
    end
    end_test("vendor_events");
    @(posedge clk);
    fault_disable <= 6'h08;
    pulse(2);
    rd(8'h80, 8'h20);
    check_bit("fault_response_enable", 1'b0, fault_response_enable);
    host_u.write_byte(8'h80, 8'h20);
    @(posedge clk);
    fault_disable <= 6'h1f;
    for (int i = 0; i < 6; i++) pulse(i);
    rd(8'h80, 8'h00);
    @(posedge clk);
    fault_disable <= 6'h00;
    end_test("fault_disable");
    @(posedge clk);
    discontinuous_mode_live <= 1'b1;
    host_u.write_byte(8'h80, 8'hff);
    rd(8'h80, 8'h80);
    check_bit("vendor_summary", 1'b0, vendor_summary);
    check_bit("first_alert_summary", 1'b0, first_alert_summary);
    @(posedge clk);
    discontinuous_mode_live <= 1'b0;
    rd(8'h80, 8'h00);
    end_test("live_mode");
    raise_alert();
    rd(8'h7f, 8'h01);
    check_bit("first_alert_summary", 1'b1, first_alert_summary);
    host_u.write_byte(8'h7f, 8'hfe);
    rd(8'h7f, 8'h01);
    host_u.write_byte(8'h7f, 8'h01);
    rd(8'h7f, 8'h00);
    check_bit("first_alert_summary", 1'b0, first_alert_summary);
    // Another device already holds the wire low, so this one is not first
    @(posedge clk);
    other_pull <= 1'b1;
    raise_alert();
    other_pull <= 1'b0;
    rd(8'h7f, 8'h00);
    end_test("first_alert");
    for (int m = 0; m < 2; m++) begin
      pulse(0);
      pulse(4);
      raise_alert();
      rd(8'h80, 8'h50);
      rd(8'h7f, 8'h01);
      @(posedge clk);
      clear_faults   <= (m == 0);
      output_turn_on <= (m == 1);
      @(posedge clk);
      {clear_faults, output_turn_on} <= 2'b00;
      rd(8'h80, 8'h00);
      rd(8'h7f, 8'h00);
    end
    end_test("bulk_clear");
    report_and_stop();
  end
endmodule // test_pmbus_aux_status_flags

/* w1c_flag.sv */
/*
  One sticky status flag: set by an event, cleared by a bulk or individual clear.
  Assumes synchronous inputs on clk.
*/
`timescale 1ns/1ps
module w1c_flag (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic set_event,
  input  wire logic clear,
  output logic      flag
);
  typedef struct packed {
    logic flag;
  } state_t;
  state_t cur;
  state_t next_cur;

  // Set wins over a clear arriving in the same cycle
  always_comb begin
    next_cur = cur;
    if (set_event) begin
      next_cur.flag = 1'b1;
    end else if (clear) begin
      next_cur.flag = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign flag = cur.flag;

  a_flag_sets : assert property (@(posedge clk) disable iff (rst)
    set_event |=> flag) else $error("flag did not set");
  a_flag_clears : assert property (@(posedge clk) disable iff (rst)
    (clear && !set_event) |=> !flag) else $error("flag did not clear");
  a_flag_holds : assert property (@(posedge clk) disable iff (rst)
    (!clear && !set_event) |=> flag == $past(flag)) else $error("flag changed alone");
endmodule // w1c_flag
